// file: common/dbs_params.svh
// constants of the two-beat split-port memory link
// assumes the including file adds nothing of its own under these names
`ifndef DBS_PARAMS_SVH
`define DBS_PARAMS_SVH

// build-time data width and the address width that goes with it
`define DBS_DATA_W            36
`define DBS_LANE_W            9
`define DBS_ADDR_W_FOR(dw)    (((dw) == 36) ? 19 : 20)

// clock figures of the controller end
`define DBS_CLK_PERIOD_NS     20
`define DBS_LINK_PERIOD_NS    160
`define DBS_K_DIV             (`DBS_LINK_PERIOD_NS / `DBS_CLK_PERIOD_NS)

// phases of the controller divider, 3 bits for a divide by 8
`define DBS_PH_W              3
`define DBS_PH_FIRST          3'h0
`define DBS_PH_STEP           3'h1
`define DBS_PH_BEAT1          3'h1
`define DBS_PH_KFALL          3'h3
`define DBS_PH_CAP1           3'h3
`define DBS_PH_CMD            3'h5
`define DBS_PH_LAST           3'h7
`define DBS_PH_CAP0           3'h7

// link cycles the controller waits after reset before taking requests
`define DBS_START_SLOTS       3'h4
`define DBS_START_STEP        3'h1
`define DBS_START_ZERO        3'h0

`endif

// file: common/dbs_pkg.sv
// types used by the controller end of the memory link
// assumes nothing of its surroundings
package dbs_pkg;

   // direction of a command on the link
   typedef enum logic {
      DBS_DIR_WRITE,
      DBS_DIR_READ
   } dbs_dir_t;

endpackage

// file: common/dbs_link_if.sv
// pins between the memory controller and the memory device
// assumes the controller drives the input and output clocks; the device returns data and echo clocks
`timescale 1ns/1ps
`include "dbs_params.svh"
interface dbs_link_if
#(
   parameter int DATA_W = `DBS_DATA_W
);
   localparam int ADDR_W = `DBS_ADDR_W_FOR(DATA_W);
   localparam int LANES  = DATA_W / `DBS_LANE_W;

   logic              k;
   logic              k_n;
   logic              c;
   logic              c_n;
   logic              cmd_valid_n;
   logic              dir_read;
   logic              dll_off_n;
   logic [ADDR_W-1:0] word_location_in;
   logic [DATA_W-1:0] write_beats_in;
   logic [LANES-1:0]  lane_write_n;
   logic [DATA_W-1:0] read_beats_out;
   logic              read_oe_n;
   logic              return_strobe_true;
   logic              return_strobe_comp;

   modport device
   (
      input  k, k_n, c, c_n, cmd_valid_n, dir_read, dll_off_n,
      input  word_location_in, write_beats_in, lane_write_n,
      output read_beats_out, read_oe_n, return_strobe_true, return_strobe_comp
   );

   modport ctrl
   (
      output k, k_n, c, c_n, cmd_valid_n, dir_read, dll_off_n,
      output word_location_in, write_beats_in, lane_write_n,
      input  read_beats_out, read_oe_n, return_strobe_true, return_strobe_comp
   );
endinterface

// file: rtl/dbs_ctrl.sv
// controller end of the memory link: divides i_clk into the link clocks
// assumes one request per link cycle at most and a device that keeps its latency
`timescale 1ns/1ps
`include "dbs_params.svh"
module dbs_ctrl
#(
   parameter int DATA_W       = `DBS_DATA_W,
   parameter bit OUT_CLK_TIED = 1'b1
)
(
   // clock, reset, enable
   input  wire logic                             i_clk,
   input  wire logic                             i_reset_n,
   input  wire logic                             i_clk_en,
   // link
   dbs_link_if.ctrl                              link,
   // request
   input  wire logic                             i_req_valid,
   input  wire logic                             i_req_read,
   input  wire logic [`DBS_ADDR_W_FOR(DATA_W)-1:0] i_req_addr,
   input  wire logic [2*DATA_W-1:0]              i_req_wdata,
   input  wire logic [2*(DATA_W/`DBS_LANE_W)-1:0] i_req_lane_n,
   output logic                                  o_req_ready,
   // read answer
   output logic                                  o_rd_valid,
   output logic [2*DATA_W-1:0]                   o_rd_data,
   // configuration
   input  wire logic                             i_dll_off_n
);
   localparam int ADDR_W = `DBS_ADDR_W_FOR(DATA_W);
   localparam int LANES  = DATA_W / `DBS_LANE_W;

   typedef struct packed {
      logic [`DBS_PH_W-1:0] ph;
      logic [`DBS_PH_W-1:0] start;
      logic                 ready;
      logic                 k;
      logic                 cmd_valid_n;
      dbs_pkg::dbs_dir_t    dir;
      logic                 dll_off_n;
      logic [ADDR_W-1:0]    addr;
      logic [DATA_W-1:0]    d;
      logic [LANES-1:0]     lane_n;
      logic [2*DATA_W-1:0]  wdata;
      logic [2*LANES-1:0]   wlane_n;
      logic [DATA_W-1:0]    w1;
      logic [LANES-1:0]     w1_lane_n;
      logic [2:0]           rd_sh;
      logic [1:0]           wr_sh;
      logic [DATA_W-1:0]    qs1;
      logic [DATA_W-1:0]    qs2;
      logic [DATA_W-1:0]    rb0;
      logic                 rd_valid;
      logic [2*DATA_W-1:0]  rd_data;
   } dbs_ctrl_state_t;

   dbs_ctrl_state_t s_q;
   dbs_ctrl_state_t s_d;

   always_comb
   begin
      logic cap0;
      logic cap1;
      cap0 = s_q.dll_off_n ? s_q.rd_sh[1] : s_q.rd_sh[0];
      cap1 = s_q.dll_off_n ? s_q.rd_sh[2] : s_q.rd_sh[1];
      s_d = s_q;
      s_d.rd_valid = 1'b0;
      s_d.ph = (s_q.ph == `DBS_PH_LAST) ? `DBS_PH_FIRST : s_q.ph + `DBS_PH_STEP;
      // read data is a pin: two flops before use
      s_d.qs1 = link.read_beats_out;
      s_d.qs2 = s_q.qs1;
      if (s_q.ph == `DBS_PH_LAST)
      begin
         s_d.k = 1'b1;
         s_d.rd_sh = {s_q.rd_sh[1:0], ~s_q.cmd_valid_n & (s_q.dir == dbs_pkg::DBS_DIR_READ)};
         s_d.wr_sh = {s_q.wr_sh[0], ~s_q.cmd_valid_n & (s_q.dir == dbs_pkg::DBS_DIR_WRITE)};
         if (s_q.start != `DBS_START_SLOTS)
            s_d.start = s_q.start + `DBS_START_STEP;
      end
      if (s_q.ph == `DBS_PH_KFALL)
         s_d.k = 1'b0;
      if (s_q.ph == `DBS_PH_CMD)
      begin
         // first beat one cycle after the write command
         if (s_q.wr_sh[0])
         begin
            s_d.d = s_q.wdata[DATA_W-1:0];
            s_d.lane_n = s_q.wlane_n[LANES-1:0];
            s_d.w1 = s_q.wdata[2*DATA_W-1:DATA_W];
            s_d.w1_lane_n = s_q.wlane_n[2*LANES-1:LANES];
         end
         // loop disable moves with the command pins, never on a k edge
         s_d.dll_off_n = i_dll_off_n;
         // load low only with a command
         s_d.cmd_valid_n = 1'b1;
         if (i_req_valid && s_q.ready)
         begin
            s_d.cmd_valid_n = 1'b0;
            s_d.dir = i_req_read ? dbs_pkg::DBS_DIR_READ : dbs_pkg::DBS_DIR_WRITE;
            s_d.addr = i_req_addr;
            s_d.wdata = i_req_wdata;
            s_d.wlane_n = i_req_lane_n;
         end
      end
      // second beat before the complementary edge
      if (s_q.ph == `DBS_PH_BEAT1 && s_q.wr_sh[1])
      begin
         s_d.d = s_q.w1;
         s_d.lane_n = s_q.w1_lane_n;
      end
      if (s_q.ph == `DBS_PH_CAP0 && cap0)
         s_d.rb0 = s_q.qs2;
      if (s_q.ph == `DBS_PH_CAP1 && cap1)
      begin
         s_d.rd_valid = 1'b1;
         s_d.rd_data = {s_q.qs2, s_q.rb0};
      end
      s_d.ready = (s_d.ph == `DBS_PH_CMD) && (s_d.start == `DBS_START_SLOTS);
      if (!i_reset_n)
      begin
         s_d = '0;
         s_d.cmd_valid_n = 1'b1;
         s_d.dll_off_n = 1'b1;
         s_d.lane_n = '1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_clk_en)
         s_q <= s_d;
   end

   assign link.k                = s_q.k;
   assign link.k_n              = ~s_q.k;
   assign link.c                = OUT_CLK_TIED ? 1'b1 : s_q.k;
   assign link.c_n              = OUT_CLK_TIED ? 1'b1 : ~s_q.k;
   assign link.cmd_valid_n      = s_q.cmd_valid_n;
   assign link.dir_read         = (s_q.dir == dbs_pkg::DBS_DIR_READ);
   assign link.dll_off_n        = s_q.dll_off_n;
   assign link.word_location_in = s_q.addr;
   assign link.write_beats_in   = s_q.d;
   assign link.lane_write_n     = s_q.lane_n;
   assign o_req_ready           = s_q.ready;
   assign o_rd_valid            = s_q.rd_valid;
   assign o_rd_data             = s_q.rd_data;
endmodule

// file: rtl/dbs_device.sv
// device end of the memory link: two-beat split-port memory with late write
// assumes the controller drives the input clock pair and waits for reset sync
`timescale 1ns/1ps
`include "dbs_params.svh"
module dbs_device
#(
   parameter int DATA_W = `DBS_DATA_W
)
(
   // link
   dbs_link_if.device  link,
   // user side
   input  wire logic   i_reset_n,
   input  wire logic   i_clk_en,
   output logic        o_dll_bypass
);
   localparam int ADDR_W = `DBS_ADDR_W_FOR(DATA_W);
   localparam int LANES  = DATA_W / `DBS_LANE_W;
   localparam int WORDS  = 2 ** (ADDR_W + 1);

   typedef struct packed {
      logic [1:0]        rst_sync;
      logic [1:0]        dll_sync;
      logic              dll_bypass;
      logic              rd_cmd;
      logic              wr_cmd;
      logic [ADDR_W-1:0] cmd_addr;
      logic              wb_valid;
      logic [ADDR_W-1:0] wb_addr;
      logic [DATA_W-1:0] wb_d0;
      logic [LANES-1:0]  wb_lane0_n;
      logic              rd_valid;
      logic [DATA_W-1:0] rd_b0;
      logic [DATA_W-1:0] rd_b1;
   } dbs_dev_state_t;

   dbs_dev_state_t    s_q;
   dbs_dev_state_t    s_d;
   logic [DATA_W-1:0] mem [WORDS];
   logic [DATA_W-1:0] d1_q;
   logic [LANES-1:0]  lane1_n_q;
   logic [DATA_W-1:0] q_fall_q;
   logic [DATA_W-1:0] q_hold_q;
   logic [DATA_W-1:0] q_rise_q;
   logic              v_fall_q;
   logic              v_hold_q;
   logic              v_rise_q;
   logic              run;
   logic              tied;
   logic              out_true;
   logic              out_comp;

   function automatic logic [DATA_W-1:0] lane_merge(
      input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w,
      input logic [LANES-1:0]  sel_n);
      logic [DATA_W-1:0] res;
      res = old_w;
      for (int i = 0; i < LANES; i++)
      begin
         if (!sel_n[i])
            res[i*`DBS_LANE_W +: `DBS_LANE_W] = new_w[i*`DBS_LANE_W +: `DBS_LANE_W];
      end
      return res;
   endfunction

   assign run = s_q.rst_sync[1];

   always_comb
   begin
      logic              fetch;
      logic [ADDR_W-1:0] faddr;
      logic [DATA_W-1:0] f0;
      logic [DATA_W-1:0] f1;
      fetch = 1'b0;
      faddr = '0;
      f0 = '0;
      f1 = '0;
      s_d = s_q;
      // reset and loop disable arrive from outside: two flops each
      s_d.rst_sync = {s_q.rst_sync[0], i_reset_n};
      s_d.dll_sync = {s_q.dll_sync[0], link.dll_off_n};
      // bypass state follows the disable pin
      s_d.dll_bypass = ~s_q.dll_sync[1];
      // command taken on the true edge
      s_d.rd_cmd = run & ~link.cmd_valid_n & link.dir_read;
      s_d.wr_cmd = run & ~link.cmd_valid_n & ~link.dir_read;
      s_d.cmd_addr = link.word_location_in;
      // address waits in the write buffer for its data
      s_d.wb_valid = s_q.wr_cmd;
      if (s_q.wr_cmd)
      begin
         s_d.wb_addr = s_q.cmd_addr;
         s_d.wb_d0 = link.write_beats_in;
         s_d.wb_lane0_n = link.lane_write_n;
      end
      fetch = s_q.dll_bypass ? s_d.rd_cmd : s_q.rd_cmd;
      faddr = s_q.dll_bypass ? link.word_location_in : s_q.cmd_addr;
      f0 = mem[{faddr, 1'b0}];
      f1 = mem[{faddr, 1'b1}];
      // buffered write committing now wins over the array
      if (s_q.wb_valid && s_q.wb_addr == faddr)
      begin
         f0 = lane_merge(f0, s_q.wb_d0, s_q.wb_lane0_n);
         f1 = lane_merge(f1, d1_q, lane1_n_q);
      end
      // bypass: first beat of a write whose data is on the pins
      if (s_q.dll_bypass && s_q.wr_cmd && s_q.cmd_addr == faddr)
         f0 = lane_merge(f0, link.write_beats_in, link.lane_write_n);
      s_d.rd_valid = fetch;
      if (fetch)
      begin
         s_d.rd_b0 = f0;
         s_d.rd_b1 = f1;
      end
      // nothing starts while held in reset
      if (!run)
      begin
         s_d.rd_cmd = 1'b0;
         s_d.wr_cmd = 1'b0;
         s_d.wb_valid = 1'b0;
         s_d.rd_valid = 1'b0;
      end
   end

   always_ff @(posedge link.k)
   begin
      if (i_clk_en)
      begin
         s_q <= s_d;
         // commit both beats of the buffered write
         if (s_q.wb_valid && run)
         begin
            mem[{s_q.wb_addr, 1'b0}] <= lane_merge(mem[{s_q.wb_addr, 1'b0}], s_q.wb_d0,
                                                   s_q.wb_lane0_n);
            mem[{s_q.wb_addr, 1'b1}] <= lane_merge(mem[{s_q.wb_addr, 1'b1}], d1_q, lane1_n_q);
         end
      end
   end

   // second beat and its selects on the complementary edge
   always_ff @(posedge link.k_n)
   begin
      if (i_clk_en)
      begin
         d1_q <= link.write_beats_in;
         lane1_n_q <= link.lane_write_n;
      end
   end

   // output clocks tied high fall back to the input pair
   assign tied     = link.c & link.c_n;
   assign out_true = tied ? link.k : link.c;
   assign out_comp = tied ? link.k_n : link.c_n;

   // first beat on the complementary output edge; second beat parked
   always_ff @(posedge out_comp)
   begin
      if (i_clk_en)
      begin
         q_fall_q <= s_q.rd_b0;
         v_fall_q <= s_q.rd_valid & run;
         q_hold_q <= s_q.rd_b1;
         v_hold_q <= s_q.rd_valid & run;
      end
   end

   // second beat on the next true output edge
   always_ff @(posedge out_true)
   begin
      if (i_clk_en)
      begin
         q_rise_q <= q_hold_q;
         v_rise_q <= v_hold_q;
      end
   end

   // double-rate read port apart from the write port
   assign link.read_beats_out = out_true ? q_rise_q : q_fall_q;
   // released unless a burst is on the wires
   assign link.read_oe_n = out_true ? ~v_rise_q : ~v_fall_q;
   // echo clocks run with the output clocks, never stop
   assign link.return_strobe_true = out_true;
   assign link.return_strobe_comp = out_comp;
   // loop disable allows only slow clocks, up to 167 MHz
   assign o_dll_bypass = s_q.dll_bypass;
endmodule

// file: bench/dbs_link_assertions.sv
// checker of the memory link pins, clocked by the true input clock
// assumes output clocks tied high and reset taken from the device side
`timescale 1ns/1ps
module dbs_link_assertions
#(
   parameter int DATA_W = 36,
   parameter int ADDR_W = 19,
   parameter int LANES  = 4
)
(
   // clocks and reset
   input wire logic              k,
   input wire logic              k_n,
   input wire logic              c,
   input wire logic              c_n,
   input wire logic              i_reset_n,
   // command and write side
   input wire logic              cmd_valid_n,
   input wire logic              dir_read,
   input wire logic              dll_off_n,
   input wire logic [ADDR_W-1:0] word_location_in,
   input wire logic [DATA_W-1:0] write_beats_in,
   input wire logic [LANES-1:0]  lane_write_n,
   // read side
   input wire logic [DATA_W-1:0] read_beats_out,
   input wire logic              read_oe_n,
   input wire logic              return_strobe_true,
   input wire logic              return_strobe_comp
);
   wire rd_cmd = !cmd_valid_n && dir_read;
   wire wr_cmd = !cmd_valid_n && !dir_read;

   default clocking cb @(posedge k); endclocking
   default disable iff (!i_reset_n);

   a_oe_read: assert property (rd_cmd && dll_off_n |-> ##2 !read_oe_n)
      else $error("read data not driven after read command");
   a_two_beats: assert property (rd_cmd && dll_off_n ##1 !rd_cmd |-> ##1 !read_oe_n ##1 read_oe_n)
      else $error("read burst not exactly one cycle long");
   a_oe_idle: assert property (dll_off_n && $past(dll_off_n) && $past(dll_off_n, 2)
      && !$past(rd_cmd, 2) |-> read_oe_n)
      else $error("read data driven without a read in flight");
   a_oe_bypass: assert property (!dll_off_n && rd_cmd |=> !read_oe_n)
      else $error("bypass read latency not one cycle");
   a_back_to_back: assert property (rd_cmd && dll_off_n ##1 rd_cmd |-> ##1 !read_oe_n [*2])
      else $error("back to back reads not continuous");
   a_write_lanes: assert property (wr_cmd |=> !(&lane_write_n))
      else $error("write beat not presented one cycle after command");
   a_echo_pair: assert property (return_strobe_true != return_strobe_comp)
      else $error("echo clocks not complementary");
   a_echo_tied: assert property (c && c_n |-> return_strobe_true == k && return_strobe_comp == k_n)
      else $error("echo clocks not following input clocks");

   c_read: cover property (rd_cmd && dll_off_n);
   c_write: cover property (wr_cmd);
   c_b2b: cover property (rd_cmd ##1 rd_cmd);
   c_bypass: cover property (!dll_off_n && rd_cmd);
endmodule

// file: bench/tb_ddr_burst2_split_io_sram_port.sv
// self-checking bench: controller and device joined by one link
// assumes default tied output clocks; device reset released after k runs
`timescale 1ns/1ps
`include "dbs_params.svh"
module tb_ddr_burst2_split_io_sram_port;
   localparam int DW = `DBS_DATA_W;
   localparam int AW = `DBS_ADDR_W_FOR(DW);
   localparam int LN = DW / `DBS_LANE_W;
   localparam int LW = `DBS_LANE_W;
   logic            clk = 1'b0;
   logic            ctrl_reset_n = 1'b0;
   logic            dev_reset_n = 1'b0;
   logic            dll_off_n = 1'b1;
   logic            req_valid = 1'b0;
   logic            req_read = 1'b0;
   logic [AW-1:0]   req_addr = '0;
   logic [2*DW-1:0] req_wdata = '0;
   logic [2*LN-1:0] req_lane_n = '1;
   logic            req_ready;
   logic            rd_valid;
   logic            dll_bypass;
   logic [2*DW-1:0] rd_data;
   logic [2*DW-1:0] mem [logic [AW-1:0]];
   logic [2*DW-1:0] got_q [$];
   logic [2*DW-1:0] exp_q [$];
   int              num_errors = 0;
   int              comparisons = 0;

   always #(`DBS_CLK_PERIOD_NS / 2) clk = ~clk;

   dbs_link_if #(.DATA_W(DW)) link_bus ();
   dbs_ctrl #(.DATA_W(DW)) i_dbs_ctrl (.i_clk(clk), .i_reset_n(ctrl_reset_n), .i_clk_en(1'b1),
      .link(link_bus), .i_req_valid(req_valid), .i_req_read(req_read), .i_req_addr(req_addr),
      .i_req_wdata(req_wdata), .i_req_lane_n(req_lane_n), .o_req_ready(req_ready),
      .o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_dll_off_n(dll_off_n));
   dbs_device #(.DATA_W(DW)) i_dbs_device (.link(link_bus), .i_reset_n(dev_reset_n),
      .i_clk_en(1'b1), .o_dll_bypass(dll_bypass));
   dbs_link_assertions #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) i_chk (.k(link_bus.k),
      .k_n(link_bus.k_n), .c(link_bus.c), .c_n(link_bus.c_n), .i_reset_n(dev_reset_n),
      .cmd_valid_n(link_bus.cmd_valid_n), .dir_read(link_bus.dir_read),
      .dll_off_n(link_bus.dll_off_n), .word_location_in(link_bus.word_location_in),
      .write_beats_in(link_bus.write_beats_in), .lane_write_n(link_bus.lane_write_n),
      .read_beats_out(link_bus.read_beats_out), .read_oe_n(link_bus.read_oe_n),
      .return_strobe_true(link_bus.return_strobe_true),
      .return_strobe_comp(link_bus.return_strobe_comp));

   // answer pulse stands one cycle, so the falling edge sees it settled
   always @(negedge clk)
      if (rd_valid === 1'b1)
         got_q.push_back(rd_data);

   task automatic results();
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [2*DW-1:0] e, input logic [2*DW-1:0] g);
      comparisons++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   // request held from a falling edge until a ready edge has taken it
   task automatic req(input logic rd, input logic [AW-1:0] a, input logic [2*DW-1:0] d,
      input logic [2*LN-1:0] ln);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_read = rd;
      req_addr = a;
      req_wdata = d;
      req_lane_n = ln;
      while (req_ready !== 1'b1 && n < 64)
      begin
         @(negedge clk);
         n++;
      end
      check("request taken", (2*DW)'(1'b1), (2*DW)'(req_ready));
      @(negedge clk);
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [2*DW-1:0] d, input logic [2*LN-1:0] ln);
      if (!mem.exists(a))
         mem[a] = 'x;
      for (int i = 0; i < 2*LN; i++)
         if (!ln[i])
            mem[a][i*LW +: LW] = d[i*LW +: LW];
      req(1'b0, a, d, ln);
   endtask

   task automatic rd(input logic [AW-1:0] a);
      exp_q.push_back(mem[a]);
      req(1'b1, a, '0, '1);
   endtask

   task automatic drain(input string what);
      int n;
      n = 0;
      req_valid = 1'b0;
      while (got_q.size() < exp_q.size() && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      repeat (32) @(negedge clk);
      check("read count", (2*DW)'(exp_q.size()), (2*DW)'(got_q.size()));
      while (exp_q.size() > 0 && got_q.size() > 0)
         check(what, exp_q.pop_front(), got_q.pop_front());
      exp_q.delete();
      got_q.delete();
   endtask

   task automatic t_full();
      wr(19'h00001, 72'h123456789abcdef012, 8'h00);
      wr(19'h7ffff, 72'hfedcba9876543210fe, 8'h00);
      rd(19'h00001);
      rd(19'h7ffff);
      drain("full burst");
   endtask

   task automatic t_lanes();
      wr(19'h00001, 72'haaaaaaaaaaaaaaaaaa, 8'h5a);
      rd(19'h00001);
      drain("lane writes");
   endtask

   task automatic t_coherent();
      wr(19'h7ffff, 72'h0f0f0f0f0f0f0f0f0f, 8'h00);
      rd(19'h7ffff);
      wr(19'h7ffff, 72'h555555555555555555, 8'h3c);
      rd(19'h7ffff);
      drain("pending write merge");
   endtask

   task automatic t_mixed();
      rd(19'h00001);
      wr(19'h2aaaa, 72'h3c3c3c3c3c3c3c3c3c, 8'h00);
      rd(19'h2aaaa);
      wr(19'h00001, 72'h0123456789abcdef01, 8'h00);
      rd(19'h00001);
      drain("interleaved");
   endtask

   task automatic t_bypass();
      dll_off_n = 1'b0;
      repeat (40) @(negedge clk);
      check("bypass flag", (2*DW)'(1'b1), (2*DW)'(dll_bypass));
      rd(19'h00001);
      rd(19'h2aaaa);
      drain("bypass read");
      dll_off_n = 1'b1;
      repeat (40) @(negedge clk);
      check("bypass flag", (2*DW)'(1'b0), (2*DW)'(dll_bypass));
   endtask

   initial
   begin
      repeat (2) @(negedge clk);
      ctrl_reset_n = 1'b1;
      // device holds reset while the divided clock runs a few cycles
      repeat (40) @(negedge clk);
      dev_reset_n = 1'b1;
      repeat (40) @(negedge clk);
      t_full();
      t_lanes();
      t_coherent();
      t_mixed();
      t_bypass();
      results();
   end

   initial
   begin
      #(`DBS_CLK_PERIOD_NS * 20000);
      num_errors++;
      results();
   end
endmodule
